/* hdl/bie_top.sv */
/*
  Sixteen-channel binary input processor: scan, filter, grouping, counting,
  event queue and indicators. Assumes inputs synchronous to MCLK and that the
  communication unit holds the configuration ports steady while CFG_VALID.
*/
`timescale 1ns/1ps
module bie_top #(
  parameter int SCAN_CYCLES = bie_pkg::SCAN_CYCLES, // clocks per scan
  parameter int FILT_SCANS  = bie_pkg::FILT_SCANS,  // debounce scans
  parameter int CONS_SCANS  = bie_pkg::CONS_SCANS,  // group stable scans
  parameter int EVT_DEPTH   = bie_pkg::EVT_DEPTH    // queue entries
) (
  input  wire logic                            MCLK,          // 20 MHz clock
  input  wire logic                            RST_N,         // async reset
  input  wire logic [bie_pkg::NUM_CH-1:0]      BIN_IN,        // process inputs
  input  wire logic                            CFG_VALID,     // config loaded
  input  wire logic [bie_pkg::NUM_CH-1:0]      CFG_CNT_EN,    // counter channels
  input  wire logic [bie_pkg::NUM_DP-1:0]      CFG_DP_EN,     // double-point pairs
  input  wire logic [1:0]                      CFG_GRP0_KIND, // low group kind
  input  wire logic [1:0]                      CFG_GRP1_KIND, // high group kind
  input  wire logic                            CFG_WORD16,    // one 16-bit group
  input  wire logic                            FREEZE,        // freeze pulse
  input  wire logic [3:0]                      CNT_SEL,       // counter to show
  input  wire logic                            FAULT_CLR,     // clear faults
  input  wire logic                            EVT_READY,     // unit takes event
  output logic                                 EVT_VALID,     // event present
  output logic      [bie_pkg::EV_W-1:0]        EVT_DATA,      // event word
  output logic      [bie_pkg::CNT_W-1:0]       CNT_RUN,       // running total
  output logic      [bie_pkg::CNT_W-1:0]       CNT_FROZEN,    // frozen total
  output logic      [bie_pkg::FLT_W-1:0]       FAULT,         // sticky faults
  output logic                                 INIT_DONE,     // first scan done
  output logic                                 LED_ERR,       // common fault led
  output logic      [bie_pkg::NUM_CH-1:0]      LED_CH         // channel leds
);
  localparam int NCH   = bie_pkg::NUM_CH;
  localparam int CW    = bie_pkg::CNT_W;
  localparam int TW    = bie_pkg::TS_W;
  localparam int DIV_W = $clog2(SCAN_CYCLES);
  localparam int PW    = $clog2(EVT_DEPTH);
  localparam int SW    = $clog2(CONS_SCANS + 1);
  localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(SCAN_CYCLES - 1);
  localparam logic [PW:0]      FULL      = (PW + 1)'(EVT_DEPTH);
  localparam logic [PW-1:0]    PTR_LAST  = PW'(EVT_DEPTH - 1);
  localparam logic [SW-1:0]    STB_FULL  = SW'(CONS_SCANS);
  localparam logic [4:0]       WALK_LAST = 5'(bie_pkg::WALK_N - 1);

  logic [NCH-1:0] filt;
  logic [NCH-1:0] diff;
  logic [NCH-1:0] sp_role;
  logic           run_en, tick;

  ////////////////////////////////////////////////////////////////////////////
  // debounce per channel
  for (genvar i = 0; i < NCH; i++) begin : g_flt
    bie_debounce #(.N(FILT_SCANS)) u_flt (
      .clk   (MCLK),
      .rst_n (RST_N),
      .tick  (tick),
      .din   (BIN_IN[i]),
      .dout  (filt[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan timebase and snapshot
  logic [DIV_W-1:0] div, next_div;
  logic             next_tick, snap, next_snap;
  logic [TW-1:0]    ms, next_ms, scan_ts, next_ts;
  logic [NCH-1:0]   cur, next_cur, chg, next_chg;
  logic [1:0]       gchg, next_gchg;
  logic [SW-1:0]    stab [2];
  logic [SW-1:0]    next_stab [2];
  logic [1:0]       gdiff;

  assign diff  = filt ^ cur;
  assign gdiff = CFG_WORD16 ? {1'b0, |diff} : {|diff[15:8], |diff[7:0]};

  // 1 ms tick, stamp and change capture one cycle after filters step
  always_comb begin
    next_tick = (div == DIV_LAST);
    next_div  = next_tick ? '0 : div + 1'b1;
    next_ms   = ms + TW'(tick);
    next_snap = tick;
    next_cur  = cur;
    next_chg  = chg;
    next_ts   = scan_ts;
    next_gchg = gchg;
    next_stab = stab;
    if (snap) begin
      next_cur  = filt;
      next_chg  = diff;
      next_ts   = ms;
      next_gchg = gdiff;
      for (int g = 0; g < 2; g++) begin
        if (gdiff[g]) begin
          next_stab[g] = '0;
        end else if (stab[g] != STB_FULL) begin
          next_stab[g] = stab[g] + 1'b1;
        end
      end
    end
  end

  // scan registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      div     <= '0;
      tick    <= 1'b0;
      ms      <= bie_pkg::TS_RST;
      snap    <= 1'b0;
      cur     <= '0;
      chg     <= '0;
      scan_ts <= bie_pkg::TS_RST;
      gchg    <= '0;
      stab    <= '{default: '0};
    end else begin
      div     <= next_div;
      tick    <= next_tick;
      ms      <= next_ms;
      snap    <= next_snap;
      cur     <= next_cur;
      chg     <= next_chg;
      scan_ts <= next_ts;
      gchg    <= next_gchg;
      stab    <= next_stab;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // integrated totals
  logic [CW-1:0] acc [NCH];
  logic [CW-1:0] hold [NCH];
  logic [CW-1:0] next_acc [NCH];
  logic [CW-1:0] next_hold [NCH];

  // one count per filtered rising edge, freeze snapshots all
  always_comb begin
    next_acc  = acc;
    next_hold = hold;
    for (int i = 0; i < NCH; i++) begin
      if (snap && run_en && CFG_CNT_EN[i] && filt[i] && !cur[i]) begin
        next_acc[i] = acc[i] + 1'b1;
      end
    end
    if (FREEZE) begin
      next_hold = acc;
    end
  end

  // counter registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      acc  <= '{default: bie_pkg::ACC_RST};
      hold <= '{default: bie_pkg::ACC_RST};
    end else begin
      acc  <= next_acc;
      hold <= next_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel roles and event walker
  bie_pkg::bie_grp_kind_t kind0, kind1, gkind;
  bie_pkg::bie_walk_t     state, next_state;
  logic [4:0]             idx, next_idx;
  logic [1:0]             dp_last [bie_pkg::NUM_DP];
  logic [1:0]             next_dp_last [bie_pkg::NUM_DP];
  logic [15:0]            grp_last [2];
  logic [15:0]            next_grp_last [2];
  logic                   init_done, next_init;
  logic                   ev_hit;
  logic [1:0]             ev_kind, pair;
  logic [15:0]            ev_val, gval;
  logic [2:0]             k;
  logic                   g;
  logic [bie_pkg::EV_W-1:0] ev_word;

  assign kind0  = bie_pkg::bie_grp_kind_t'(CFG_GRP0_KIND);
  assign kind1  = bie_pkg::bie_grp_kind_t'(CFG_GRP1_KIND);
  assign run_en = CFG_VALID && init_done;

  // a channel is single-point unless claimed elsewhere
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      sp_role[i] = !CFG_DP_EN[i/2] && !CFG_CNT_EN[i] &&
                   !((CFG_WORD16 || i < 8) ? (kind0 != bie_pkg::GK_NONE)
                                           : (kind1 != bie_pkg::GK_NONE));
    end
  end

  // event source selected by walk index
  always_comb begin
    k       = idx[2:0];
    g       = idx[0];
    pair    = {cur[{k, 1'b1}], cur[{k, 1'b0}]};
    gkind   = (g && CFG_WORD16) ? bie_pkg::GK_NONE : (g ? kind1 : kind0);
    gval    = CFG_WORD16 ? cur : (g ? {8'h00, cur[15:8]} : {8'h00, cur[7:0]});
    ev_hit  = 1'b0;
    ev_kind = bie_pkg::EK_SINGLE;
    ev_val  = {15'h0000, cur[idx[3:0]]};
    if (idx < 5'h10) begin
      ev_hit = chg[idx[3:0]] && sp_role[idx[3:0]];
    end else if (idx < 5'h18) begin
      ev_kind = bie_pkg::EK_DOUBLE;
      ev_val  = {14'h0000, pair};
      ev_hit  = CFG_DP_EN[k] && (pair == 2'h1 || pair == 2'h2) &&
                pair != dp_last[k];
    end else begin
      ev_kind = bie_pkg::EK_GROUP;
      ev_val  = gval;
      if (gkind == bie_pkg::GK_BITS) begin
        ev_hit = gchg[g];
      end else if (gkind != bie_pkg::GK_NONE) begin
        ev_hit = stab[g] == STB_FULL && gval != grp_last[g];
      end
    end
    ev_hit  = ev_hit && run_en && state == bie_pkg::WK_RUN;
    ev_word = {ev_kind, idx, ev_val, scan_ts};
  end

  // walker steps through all sources once per scan
  always_comb begin
    next_state    = state;
    next_idx      = idx;
    next_dp_last  = dp_last;
    next_grp_last = grp_last;
    next_init     = init_done | snap;
    case (state)
      bie_pkg::WK_IDLE: begin
        if (snap) begin
          next_state = bie_pkg::WK_RUN;
          next_idx   = '0;
        end
      end
      bie_pkg::WK_RUN: begin
        next_idx = idx + 1'b1;
        if (idx == WALK_LAST) begin
          next_state = bie_pkg::WK_IDLE;
        end
      end
      default: next_state = bie_pkg::WK_IDLE;
    endcase
    if (ev_hit && ev_kind == bie_pkg::EK_DOUBLE) begin
      next_dp_last[k] = pair;
    end
    if (ev_hit && ev_kind == bie_pkg::EK_GROUP) begin
      next_grp_last[g] = gval;
    end
  end

  // walker registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state     <= bie_pkg::WK_IDLE;
      idx       <= '0;
      dp_last   <= '{default: '0};
      grp_last  <= '{default: '0};
      init_done <= 1'b0;
    end else begin
      state     <= next_state;
      idx       <= next_idx;
      dp_last   <= next_dp_last;
      grp_last  <= next_grp_last;
      init_done <= next_init;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event queue and two-entry output buffer
  logic [PW-1:0]  wr_ptr, next_wr, rd_ptr, next_rd;
  logic [PW:0]    fcnt, next_fcnt, lvl;
  logic           do_wr, do_rd, ovf, pop, rd_pend;
  logic [1:0]     occ;
  logic [bie_pkg::EV_W-1:0] mem_q, b0, b1, next_b0, next_b1;
  logic           v0, v1, next_v0, next_v1;

  bie_evt_mem #(.W(bie_pkg::EV_W), .DEPTH(EVT_DEPTH), .AW(PW)) u_mem (
    .clk   (MCLK),
    .rst_n (RST_N),
    .we    (do_wr),
    .waddr (wr_ptr),
    .wdata (ev_word),
    .re    (do_rd),
    .raddr (rd_ptr),
    .q     (mem_q)
  );

  // full queue drops, reads only while the buffer has room
  always_comb begin
    do_wr     = ev_hit && fcnt != FULL;
    ovf       = ev_hit && fcnt == FULL;
    occ       = {1'b0, v0} + {1'b0, v1} + {1'b0, rd_pend};
    do_rd     = fcnt != '0 && occ < 2'h2;
    next_wr   = do_wr ? ((wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd   = do_rd ? ((rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_fcnt = fcnt + (PW + 1)'(do_wr) - (PW + 1)'(do_rd);
    pop       = v0 && EVT_READY;
    next_b0   = b0;
    next_b1   = b1;
    next_v0   = v0;
    next_v1   = v1;
    if (pop) begin
      next_b0 = b1;
      next_v0 = v1;
      next_v1 = 1'b0;
    end
    if (rd_pend) begin
      if (!next_v0) begin
        next_b0 = mem_q;
        next_v0 = 1'b1;
      end else begin
        next_b1 = mem_q;
        next_v1 = 1'b1;
      end
    end
  end

  // queue registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      fcnt    <= '0;
      rd_pend <= 1'b0;
      b0      <= '0;
      b1      <= '0;
      v0      <= 1'b0;
      v1      <= 1'b0;
    end else begin
      wr_ptr  <= next_wr;
      rd_ptr  <= next_rd;
      fcnt    <= next_fcnt;
      rd_pend <= do_rd;
      b0      <= next_b0;
      b1      <= next_b1;
      v0      <= next_v0;
      v1      <= next_v1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // faults, indicators and counter readout
  logic [bie_pkg::FLT_W-1:0] flt_set, next_flt;

  // pointer-level cross check, overrun and overflow; set beats clear
  always_comb begin
    lvl = (wr_ptr >= rd_ptr) ? {1'b0, wr_ptr} - {1'b0, rd_ptr}
                             : {1'b0, wr_ptr} + FULL - {1'b0, rd_ptr};
    flt_set = '0;
    flt_set[bie_pkg::FLT_OVF]     = ovf;
    flt_set[bie_pkg::FLT_OVERRUN] = snap && state == bie_pkg::WK_RUN;
    flt_set[bie_pkg::FLT_FIFO]    = fcnt != lvl && !(fcnt == FULL && lvl == '0);
    next_flt = (FAULT & ~{bie_pkg::FLT_W{FAULT_CLR}}) | flt_set;
  end

  // status and indicator registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      FAULT      <= '0;
      LED_ERR    <= 1'b0;
      LED_CH     <= '0;
      CNT_RUN    <= bie_pkg::ACC_RST;
      CNT_FROZEN <= bie_pkg::ACC_RST;
      INIT_DONE  <= 1'b0;
    end else begin
      FAULT      <= next_flt;
      LED_ERR    <= |next_flt;
      LED_CH     <= filt;
      CNT_RUN    <= acc[CNT_SEL];
      CNT_FROZEN <= hold[CNT_SEL];
      INIT_DONE  <= next_init;
    end
  end

  assign EVT_VALID = v0;
  assign EVT_DATA  = b0;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [TW-1:0] last_ts;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) last_ts <= '0;
    else if (pop) last_ts <= b0[TW-1:0];
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  chk_scan_gap: assert property (tick |=> !tick [*8])
    else $error("scan ticks too close");
  chk_led_track: assert property (1'b1 |=> LED_CH == $past(filt))
    else $error("channel led does not follow input");
  chk_full_drop: assert property (ovf |=> FAULT[0] && wr_ptr == $past(wr_ptr))
    else $error("full queue overwritten or unflagged");
  chk_depth_cap: assert property (fcnt <= FULL)
    else $error("queue level above depth");
  chk_pop_order: assert property (pop |-> b0[TW-1:0] >= last_ts)
    else $error("event older than previous one");
  chk_freeze_copy: assert property (FREEZE |=> hold[0] == $past(acc[0]))
    else $error("freeze missed running total");
  chk_count_step: assert property ((snap && run_en && CFG_CNT_EN[0] && filt[0] && !cur[0])
    |=> acc[0] == $past(acc[0]) + 1'b1)
    else $error("pulse not counted");
  chk_dp_ends: assert property ((ev_hit && ev_kind == bie_pkg::EK_DOUBLE)
    |-> ev_val[1] != ev_val[0])
    else $error("intermediate double state reported");
  chk_cfg_gate: assert property (!CFG_VALID |-> !ev_hit)
    else $error("event before configuration");
  chk_err_led: assert property (FAULT != '0 |-> LED_ERR)
    else $error("fault without red led");
  chk_stamp_take: assert property (snap |=> scan_ts == $past(ms))
    else $error("scan stamp not captured");

  cov_overflow: cover property (ovf);
  cov_double: cover property (ev_hit && ev_kind == bie_pkg::EK_DOUBLE);
  cov_stall_pop: cover property (v1 && !EVT_READY ##1 pop);
endmodule

/* hdl/bie_pkg.sv */
/*
  Shared constants and types of the binary input event processor.
  Assumes a 20 MHz core clock; all users reference items as bie_pkg::name.
*/
package bie_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SCAN_PERIOD_NS = 1000000;
  localparam int SCAN_CYCLES    = SCAN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FILT_SCANS     = 3;     // scans a new level must persist
  localparam int CONS_SCANS     = 2;     // stable scans before a group value counts

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_CH    = 16;
  localparam int NUM_DP    = 8;
  localparam int EVT_DEPTH = 50;
  localparam int CNT_W     = 31;
  localparam int TS_W      = 32;
  localparam int WALK_N    = 26;         // 16 single, 8 double, 2 groups

  ////////////////////////////////////////////////////////////////////////////
  // event word layout
  localparam int EV_TS_LSB   = 0;
  localparam int EV_VAL_LSB  = 32;
  localparam int EV_IDX_LSB  = 48;
  localparam int EV_KIND_LSB = 53;
  localparam int EV_W        = 55;

  localparam logic [1:0] EK_SINGLE = 2'h0;
  localparam logic [1:0] EK_DOUBLE = 2'h1;
  localparam logic [1:0] EK_GROUP  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // fault bits
  localparam int FLT_OVF     = 0;
  localparam int FLT_OVERRUN = 1;
  localparam int FLT_FIFO    = 2;
  localparam int FLT_W       = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [CNT_W-1:0] ACC_RST = 31'h0;
  localparam logic [TS_W-1:0]  TS_RST  = 32'h0;

  typedef enum logic [1:0] {GK_NONE, GK_MEAS, GK_STEP, GK_BITS} bie_grp_kind_t;
  typedef enum logic {WK_IDLE, WK_RUN} bie_walk_t;

endpackage

/* hdl/bie_debounce.sv */
/*
  One-channel contact bounce filter, stepped by the scan tick.
  Assumes din is synchronous to clk and tick is a one-cycle pulse.
*/
`timescale 1ns/1ps
module bie_debounce #(
  parameter int N = bie_pkg::FILT_SCANS
) (
  input  wire logic clk,   // core clock
  input  wire logic rst_n, // async reset, low
  input  wire logic tick,  // scan pulse
  input  wire logic din,   // raw level
  output logic      dout   // filtered level
);
  localparam int CW = $clog2(N + 1);
  localparam logic [CW-1:0] CLAST = CW'(N - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_dout;

  // new level taken only after N differing scans in a row
  always_comb begin
    next_cnt  = cnt;
    next_dout = dout;
    if (tick) begin
      if (din == dout) begin
        next_cnt = '0;
      end else if (cnt == CLAST) begin
        next_cnt  = '0;
        next_dout = din;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      dout <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      dout <= next_dout;
    end
  end

  chk_filt_on_tick: assert property (@(posedge clk) disable iff (!rst_n)
    !$stable(dout) |-> $past(tick))
    else $error("filtered level moved off a scan");
endmodule

/* hdl/bie_evt_mem.sv */
/*
  Event storage array: one write port, one read port with registered data.
  Assumes the caller keeps its own pointers and never reads an empty slot.
*/
`timescale 1ns/1ps
module bie_evt_mem #(
  parameter int W     = bie_pkg::EV_W,
  parameter int DEPTH = bie_pkg::EVT_DEPTH,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk,   // core clock
  input  wire logic          rst_n, // async reset, low
  input  wire logic          we,    // write strobe
  input  wire logic [AW-1:0] waddr, // write slot
  input  wire logic [W-1:0]  wdata, // write word
  input  wire logic          re,    // read strobe
  input  wire logic [AW-1:0] raddr, // read slot
  output logic      [W-1:0]  q      // read word, next cycle
);
  logic [W-1:0] mem [DEPTH];

  // array write, no reset on storage
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (re) begin
      q <= mem[raddr];
    end
  end
endmodule

/* sim/bie_cmu_model.sv */
/*
  communication unit model: takes event words from the queue port.
  assumes one clock; the bench sets stall and slow.
*/
`timescale 1ns/1ps
module bie_cmu_model (
  input  wire logic                     mclk,      // core clock
  input  wire logic                     stall,     // refuse every event
  input  wire logic                     slow,      // accept every other cycle
  input  wire logic                     evt_valid, // event present
  input  wire logic [bie_pkg::EV_W-1:0] evt_data,  // event word
  output logic                          evt_ready  // event taken
);
  logic [bie_pkg::EV_W-1:0] words [0:127];
  int                       n  = 0;
  logic                     ph = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // ready moves just after the falling edge
  initial evt_ready = 1'b0;
  always @(negedge mclk) begin
    ph        <= ~ph;
    evt_ready <= ~stall & (~slow | ph);
  end
  // words kept in arrival order
  always @(posedge mclk) begin
    if (evt_valid && evt_ready) begin
      words[n] = evt_data;
      n = n + 1;
    end
  end
endmodule

/* sim/binary_input_event_processor_tb.sv */
/*
  self-checking bench of the input processor, small scan period.
  assumes the communication unit model answers the event port.
*/
`timescale 1ns/1ps
module binary_input_event_processor_tb;
  localparam int SC = 40;
  logic        MCLK = 0, RST_N = 0, FREEZE = 0, FAULT_CLR = 0, stall = 0, slow = 0;
  logic        CFG_VALID = 0, CFG_WORD16 = 0, EVT_READY, EVT_VALID, LED_ERR, INIT_DONE;
  logic [15:0] BIN_IN = 16'h0000, CFG_CNT_EN = 16'h0040, LED_CH;
  logic [7:0]  CFG_DP_EN = 8'h04;
  logic [1:0]  CFG_GRP0_KIND = 2'h0, CFG_GRP1_KIND = 2'h0;
  logic [3:0]  CNT_SEL = 4'h6;
  logic [54:0] EVT_DATA;
  logic [30:0] CNT_RUN, CNT_FROZEN;
  logic [2:0]  FAULT;
  int          fails = 0, comparisons = 0, b;
  ////////////////////////////////////////////////////////////////////////////
  // clock and instances
  always #25 MCLK = ~MCLK;
  bie_top #(.SCAN_CYCLES(SC)) dut (.MCLK(MCLK), .RST_N(RST_N), .BIN_IN(BIN_IN),
    .CFG_VALID(CFG_VALID), .CFG_CNT_EN(CFG_CNT_EN), .CFG_DP_EN(CFG_DP_EN),
    .CFG_GRP0_KIND(CFG_GRP0_KIND), .CFG_GRP1_KIND(CFG_GRP1_KIND), .CFG_WORD16(CFG_WORD16),
    .FREEZE(FREEZE), .CNT_SEL(CNT_SEL), .FAULT_CLR(FAULT_CLR), .EVT_READY(EVT_READY),
    .EVT_VALID(EVT_VALID), .EVT_DATA(EVT_DATA), .CNT_RUN(CNT_RUN), .CNT_FROZEN(CNT_FROZEN),
    .FAULT(FAULT), .INIT_DONE(INIT_DONE), .LED_ERR(LED_ERR), .LED_CH(LED_CH));
  bie_cmu_model cmu (.mclk(MCLK), .stall(stall), .slow(slow), .evt_valid(EVT_VALID),
    .evt_data(EVT_DATA), .evt_ready(EVT_READY));
  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [54:0] got, input logic [54:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic scans(input int k);
    repeat (k * SC) @(negedge MCLK);
  endtask
  task automatic ev(input int j, input logic [1:0] k, input logic [4:0] i, input logic [15:0] v);
    chk(cmu.words[j][54:32], {k, i, v}, "event");
  endtask
  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_config;
    BIN_IN[0] = 1'b1;
    scans(5);
    chk(INIT_DONE, 1'b1, "init");
    chk(cmu.n, 0, "events before config");
    chk(LED_CH, 16'h0001, "led");
    BIN_IN[0] = 1'b0;
    scans(5);
    CFG_VALID = 1'b1;
    $display("config test done");
  endtask
  task automatic t_filter;
    b = cmu.n;
    BIN_IN[0] = 1'b1;
    scans(2);
    BIN_IN[0] = 1'b0;
    scans(4);
    chk(LED_CH[0], 1'b0, "bounce");
    chk(cmu.n, b, "bounce event");
    BIN_IN[0] = 1'b1;
    scans(5);
    chk(LED_CH[0], 1'b1, "led on");
    BIN_IN[0] = 1'b0;
    scans(5);
    chk(cmu.n, b + 2, "count");
    ev(b, bie_pkg::EK_SINGLE, 5'h00, 16'h0001);
    ev(b + 1, bie_pkg::EK_SINGLE, 5'h00, 16'h0000);
    $display("filter test done");
  endtask
  task automatic t_order;
    b = cmu.n;
    BIN_IN[3:1] = 3'h5;
    scans(2);
    BIN_IN[2] = 1'b1;
    scans(6);
    chk(cmu.n, b + 3, "count");
    ev(b, bie_pkg::EK_SINGLE, 5'h01, 16'h0001);
    ev(b + 1, bie_pkg::EK_SINGLE, 5'h03, 16'h0001);
    ev(b + 2, bie_pkg::EK_SINGLE, 5'h02, 16'h0001);
    chk(cmu.words[b + 1][31:0], cmu.words[b][31:0], "stamp");
    chk(cmu.words[b + 2][31:0], cmu.words[b][31:0] + 32'h2, "stamp");
    $display("order test done");
  endtask
  task automatic t_double;
    b = cmu.n;
    BIN_IN[5:4] = 2'h3;
    scans(5);
    chk(cmu.n, b, "intermediate");
    BIN_IN[5:4] = 2'h1;
    scans(5);
    chk(cmu.n, b + 1, "count");
    ev(b, bie_pkg::EK_DOUBLE, 5'h12, 16'h0001);
    $display("double test done");
  endtask
  task automatic t_count;
    for (int p = 0; p < 5; p++) begin
      if (p == 3) begin
        FREEZE = 1'b1;
        @(negedge MCLK);
        FREEZE = 1'b0;
      end
      BIN_IN[6] = 1'b1;
      scans(20); // 12.5 kHz pulse
      BIN_IN[6] = 1'b0;
      scans(20);
    end
    chk(CNT_RUN, 31'h5, "running");
    chk(CNT_FROZEN, 31'h3, "frozen");
    $display("count test done");
  endtask
  task automatic t_overflow;
    stall = 1'b1;
    for (int t = 0; t < 5; t++) begin
      BIN_IN = BIN_IN ^ 16'hFF0F;
      scans(5);
    end
    chk(FAULT[0], 1'b1, "overflow");
    chk(LED_ERR, 1'b1, "fault led");
    b = cmu.n;
    stall = 1'b0;
    slow = 1'b1;
    scans(5);
    chk((cmu.n - b >= 50) && (cmu.n - b <= 52), 1'b1, "kept");
    for (int j = b + 1; j < cmu.n; j++) begin
      chk(cmu.words[j][31:0] >= cmu.words[j - 1][31:0], 1'b1, "age");
    end
    FAULT_CLR = 1'b1;
    @(negedge MCLK);
    FAULT_CLR = 1'b0;
    @(negedge MCLK);
    chk({FAULT, LED_ERR}, 4'h0, "clear");
    $display("overflow test done");
  endtask
  // low byte measured, high byte bitstring, then one 16-bit step word
  task automatic t_group;
    b = cmu.n;
    CFG_GRP0_KIND = 2'h1;
    CFG_GRP1_KIND = 2'h3;
    scans(2);
    BIN_IN[15:8] = 8'h5A;
    BIN_IN[1] = 1'b1;
    scans(1);
    BIN_IN[3] = 1'b1;
    scans(7);
    chk(cmu.n, b + 3, "group count");
    ev(b, bie_pkg::EK_GROUP, 5'h18, 16'h0011);
    ev(b + 1, bie_pkg::EK_GROUP, 5'h19, 16'h005A);
    ev(b + 2, bie_pkg::EK_GROUP, 5'h18, 16'h001B);
    CFG_WORD16 = 1'b1;
    CFG_GRP0_KIND = 2'h2;
    scans(2);
    chk(cmu.n, b + 4, "word count");
    ev(b + 3, bie_pkg::EK_GROUP, 5'h18, 16'h5A1B);
    $display("group test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (4) @(negedge MCLK);
    RST_N = 1'b1;
    t_config;
    t_filter;
    t_order;
    t_double;
    t_count;
    t_overflow;
    t_group;
    finish_test;
  end
  initial begin
    repeat (30000) @(posedge MCLK);
    fails++;
    finish_test;
  end
endmodule
